// ---- usb_peripheral_interrupt_enable_test.sv ----
// self-checking bench for the usb interrupt enable block
`timescale 1ns/100ps
`default_nettype none
`include "usbie_consts.svh"
module usb_peripheral_interrupt_enable_test
    import usbie_pkg::*;
;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic shake_valid, shake_tx, shake_nak, shake_setup;
    logic [2:0] shake_ep;
    logic ev_sof, ev_suspend, ev_resume, ev_bus_reset, ev_setup, ev_hs_status;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int evb [6];
    int k, s, n;
    logic hit, hit0;

    usbie_ctrl u_usbie_ctrl (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .shake_valid(shake_valid), .shake_ep(shake_ep),
        .shake_tx(shake_tx), .shake_nak(shake_nak),
        .shake_setup(shake_setup), .ev_sof(ev_sof),
        .ev_suspend(ev_suspend), .ev_resume(ev_resume),
        .ev_bus_reset(ev_bus_reset), .ev_setup(ev_setup),
        .ev_hs_status(ev_hs_status), .irq(irq));

    usbie_sie_model u_usbie_sie_model (.aclk(aclk),
        .shake_valid(shake_valid), .shake_ep(shake_ep),
        .shake_tx(shake_tx), .shake_nak(shake_nak),
        .shake_setup(shake_setup), .ev_sof(ev_sof),
        .ev_suspend(ev_suspend), .ev_resume(ev_resume),
        .ev_bus_reset(ev_bus_reset), .ev_setup(ev_setup),
        .ev_hs_status(ev_hs_status));

    ////////////////////////////////////////////////////////////////////////
    // 100 ns clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // hang guard, generous against roughly 300 cycles of traffic
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            $display("mismatch at %0t: timeout", $time);
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input usbie_word_t got, input usbie_word_t exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write: address and data offered together, bready held up
    task automatic wr(input usbie_addr_t a, input usbie_word_t d,
                      input logic [1:0] er);
        logic ad;
        logic dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!dd && wready) begin
                dd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    // axi4-lite read with response and data compared
    task automatic rc(input usbie_addr_t a, input usbie_word_t exp,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        chk({30'h0, rresp}, {30'h0, er});
        chk(rdata, exp);
    endtask

    // irq is registered one edge behind its cause, so let two edges pass
    task automatic irq_is(input logic e);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        evb = '{`USBIE_BIT_BRST, `USBIE_BIT_SOF, `USBIE_BIT_SUSP,
                `USBIE_BIT_RESUME, `USBIE_BIT_HSSTAT, `USBIE_BIT_SETUP};
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, read-only and unmapped places
        rc(`USBIE_OFS_IE, `USBIE_IE_RESET, `USBIE_RESP_OKAY);
        rc(`USBIE_OFS_MODE, `USBIE_MODE_RESET, `USBIE_RESP_OKAY);
        rc(8'h40, `USBIE_WORD_ZERO, `USBIE_RESP_SLVERR);
        wr(8'h40, 32'hFFFF_FFFF, `USBIE_RESP_SLVERR);
        wr(`USBIE_OFS_STAT, 32'hFFFF_FFFF, `USBIE_RESP_OKAY);
        rc(`USBIE_OFS_STAT, `USBIE_WORD_ZERO, `USBIE_RESP_OKAY);
        wr(`USBIE_OFS_IE, 32'hFFFF_FFFF, `USBIE_RESP_OKAY);
        rc(`USBIE_OFS_IE, `USBIE_IE_MASK, `USBIE_RESP_OKAY);
        rc(`USBIE_OFS_CLR, `USBIE_WORD_ZERO, `USBIE_RESP_OKAY);
        // each bus event except bus reset with everything enabled
        wr(`USBIE_OFS_MODE, `USBIE_WORD_ONE, `USBIE_RESP_OKAY);
        for (k = 1; k < 6; k++) begin
            u_usbie_sie_model.pulse(k);
            irq_is(1'b1);
            rc(`USBIE_OFS_STAT, 32'h1 << evb[k], `USBIE_RESP_OKAY);
            wr(`USBIE_OFS_CLR, 32'hFFFF_FFFF, `USBIE_RESP_OKAY);
            irq_is(1'b0);
        end
        // master enable off hides a latched event
        wr(`USBIE_OFS_MODE, `USBIE_WORD_ZERO, `USBIE_RESP_OKAY);
        u_usbie_sie_model.pulse(1);
        irq_is(1'b0);
        wr(`USBIE_OFS_MODE, `USBIE_WORD_ONE, `USBIE_RESP_OKAY);
        irq_is(1'b1);
        wr(`USBIE_OFS_CLR, 32'hFFFF_FFFF, `USBIE_RESP_OKAY);
        // every select code against ack and nak; control select mirrored
        // so that endpoint 0 and the data endpoints disagree in each pass
        for (s = 0; s < 4; s++) begin
            for (n = 0; n < 2; n++) begin
                hit = (s == 0) || (s == 1 && n == 0) || (s == 2 && n == 1);
                hit0 = (s == 3) || (s == 2 && n == 0) || (s == 1 && n == 1);
                wr(`USBIE_OFS_CFG,
                   usbie_word_t'((3 - s) | (s << 2) | (s << 4)),
                   `USBIE_RESP_OKAY);
                u_usbie_sie_model.shake(3'h2, 1'b1, n[0], 1'b0);
                u_usbie_sie_model.shake(3'h3, 1'b0, n[0], 1'b0);
                u_usbie_sie_model.shake(3'h0, 1'b1, n[0], 1'b0);
                rc(`USBIE_OFS_STAT,
                   (hit ? 32'h0001_8000 : 32'h0) | (hit0 ? 32'h800 : 32'h0),
                   `USBIE_RESP_OKAY);
                wr(`USBIE_OFS_CLR, 32'hFFFF_FFFF, `USBIE_RESP_OKAY);
            end
        end
        // endpoint 0 follows only the control select, setup lands on rx
        wr(`USBIE_OFS_CFG, 32'h0000_003C, `USBIE_RESP_OKAY);
        u_usbie_sie_model.shake(3'h0, 1'b0, 1'b0, 1'b1);
        u_usbie_sie_model.shake(3'h0, 1'b1, 1'b1, 1'b0);
        u_usbie_sie_model.shake(3'h1, 1'b1, 1'b0, 1'b0);
        u_usbie_sie_model.shake(3'h1, 1'b0, 1'b0, 1'b0);
        rc(`USBIE_OFS_STAT, 32'h0000_0C00, `USBIE_RESP_OKAY);
        // only the matching endpoint and direction bit lets irq through
        wr(`USBIE_OFS_IE, 32'h0000_1000, `USBIE_RESP_OKAY);
        irq_is(1'b0);
        wr(`USBIE_OFS_IE, 32'h0000_0800, `USBIE_RESP_OKAY);
        irq_is(1'b1);
        // bus reset keeps only its own enable
        wr(`USBIE_OFS_IE, 32'hFFFF_FFFF, `USBIE_RESP_OKAY);
        wr(`USBIE_OFS_CLR, 32'hFFFF_FFFF, `USBIE_RESP_OKAY);
        u_usbie_sie_model.pulse(0);
        irq_is(1'b1);
        rc(`USBIE_OFS_IE, `USBIE_IE_AFTER_BRST, `USBIE_RESP_OKAY);
        rc(`USBIE_OFS_STAT, 32'h0000_0001, `USBIE_RESP_OKAY);
        end_of_test();
    end
endmodule
`default_nettype wire

// ---- usbie_consts.svh ----
// constants for the usb peripheral interrupt enable block
// Summary of operation
// - each endpoint has its own receive and transmit interrupt enable bit
// - master enable cleared in mode register blocks every interrupt
// - ack or nak handshake on an enabled endpoint raises its interrupt
// - three two-bit select fields decide which handshakes raise interrupts
// - data in transactions use transmit bits, qualified by data-in select
// - data out transactions use receive bits, qualified by data-out select
// - endpoint 0 in, out and setup use only the control select
// - sof, suspend, resume, bus reset, setup, high-speed have own enables
// - usb bus reset clears all enables except bus reset enable, kept at 1
// - enable register is one 32-bit word at address 14h
`ifndef USBIE_CONSTS_SVH
`define USBIE_CONSTS_SVH

// register byte addresses
`define USBIE_OFS_MODE 8'h0C
`define USBIE_OFS_CFG 8'h10
`define USBIE_OFS_IE 8'h14
`define USBIE_OFS_STAT 8'h18
`define USBIE_OFS_CLR 8'h1C

// mode and configuration fields
`define USBIE_BIT_MASTER 0
`define USBIE_MODE_MASK 32'h0000_0001
`define USBIE_MODE_RESET 32'h0000_0000
`define USBIE_CFG_MASK 32'h0000_003F
`define USBIE_CFG_RESET 32'h0000_0000
`define USBIE_CFG_CTRL_LSB 0
`define USBIE_CFG_IN_LSB 2
`define USBIE_CFG_OUT_LSB 4

// enable and status layout
`define USBIE_BIT_BRST 0
`define USBIE_BIT_SOF 1
`define USBIE_BIT_SUSP 2
`define USBIE_BIT_RESUME 3
`define USBIE_BIT_HSSTAT 4
`define USBIE_BIT_SETUP 8
`define USBIE_BIT_EP_BASE 5'h0A
`define USBIE_IE_MASK 32'h03FF_FD1F
`define USBIE_IE_RESET 32'h0000_0000
`define USBIE_IE_AFTER_BRST 32'h0000_0001

// handshake select encodings
`define USBIE_SEL_BOTH 2'h0
`define USBIE_SEL_ACK 2'h1
`define USBIE_SEL_NAK 2'h2
`define USBIE_SEL_OFF 2'h3

// bus answers
`define USBIE_RESP_OKAY 2'h0
`define USBIE_RESP_SLVERR 2'h2
`define USBIE_WORD_ZERO 32'h0000_0000
`define USBIE_WORD_ONE 32'h0000_0001

`endif

// ---- usbie_ctrl.sv ----
// interrupt enable, status and gating with an axi4-lite register slave
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "usbie_consts.svh"
module usbie_ctrl
    import usbie_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // handshake reports from the serial interface engine
    input wire logic shake_valid,
    input wire logic [2:0] shake_ep,
    input wire logic shake_tx,
    input wire logic shake_nak,
    input wire logic shake_setup,
    // bus event pulses
    input wire logic ev_sof,
    input wire logic ev_suspend,
    input wire logic ev_resume,
    input wire logic ev_bus_reset,
    input wire logic ev_setup,
    input wire logic ev_hs_status,
    // interrupt request
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // registers and internal signals

    usbie_word_t mode;
    usbie_word_t cfg;
    usbie_word_t ie;
    usbie_word_t stat;
    usbie_word_t stat_set;
    usbie_word_t stat_clr;
    usbie_word_t shake_vec;
    usbie_word_t bus_vec;
    usbie_word_t next_rdata;
    usbie_addr_t aw_addr;
    usbie_word_t w_data;
    logic [3:0] w_strb;
    logic aw_full;
    logic w_full;
    logic wr_go;
    logic wr_hit;
    logic rd_hit;
    logic master_irq_enable;
    logic [4:0] shake_idx;
    usbie_sel_t shake_sel;
    usbie_sel_t control_handshake_irq_select;
    usbie_sel_t data_in_handshake_irq_select;
    usbie_sel_t data_out_handshake_irq_select;
    logic shake_allow;

    // byte-lane merge limited to implemented bits
    function automatic usbie_word_t merge(
        input usbie_word_t old,
        input usbie_word_t nw,
        input logic [3:0] strb,
        input usbie_word_t keep
    );
        usbie_word_t m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        m = m & keep;
        return (old & ~m) | (nw & m);
    endfunction

    // word-aligned decode of a mapped register
    function automatic logic mapped(input usbie_addr_t a);
        return (a[7:2] == `USBIE_OFS_MODE >> 2)
            || (a[7:2] == `USBIE_OFS_CFG >> 2)
            || (a[7:2] == `USBIE_OFS_IE >> 2)
            || (a[7:2] == `USBIE_OFS_STAT >> 2)
            || (a[7:2] == `USBIE_OFS_CLR >> 2);
    endfunction

    function automatic logic at(input usbie_addr_t a, input usbie_addr_t o);
        return a[7:2] == o[7:2];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // axi4-lite write channel

    // address and data are taken independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            aw_full <= 1'b0;
            aw_addr <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_full <= 1'b1;
            aw_addr <= awaddr;
        end else if (wr_go) begin
            aw_full <= 1'b0;
        end else if (!aw_full && !bvalid) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b0;
            w_full <= 1'b0;
            w_data <= `USBIE_WORD_ZERO;
            w_strb <= '0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_full <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
        end else if (wr_go) begin
            w_full <= 1'b0;
        end else if (!w_full && !bvalid) begin
            wready <= 1'b1;
        end
    end

    // commit once both halves are held and no response is pending
    assign wr_go = aw_full && w_full && !bvalid;
    assign wr_hit = mapped(aw_addr);

    // response: unmapped addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `USBIE_RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? `USBIE_RESP_OKAY : `USBIE_RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi4-lite read channel

    assign rd_hit = mapped(araddr);

    // clear register is write-only and reads zero
    always_comb begin
        next_rdata = `USBIE_WORD_ZERO;
        if (at(araddr, `USBIE_OFS_MODE)) begin
            next_rdata = mode;
        end else if (at(araddr, `USBIE_OFS_CFG)) begin
            next_rdata = cfg;
        end else if (at(araddr, `USBIE_OFS_IE)) begin
            next_rdata = ie;
        end else if (at(araddr, `USBIE_OFS_STAT)) begin
            next_rdata = stat;
        end
    end

    // one read at a time, data sampled at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= `USBIE_WORD_ZERO;
            rresp <= `USBIE_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= rd_hit ? `USBIE_RESP_OKAY : `USBIE_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= `USBIE_MODE_RESET;
        end else if (wr_go && at(aw_addr, `USBIE_OFS_MODE)) begin
            mode <= merge(mode, w_data, w_strb, `USBIE_MODE_MASK);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= `USBIE_CFG_RESET;
        end else if (wr_go && at(aw_addr, `USBIE_OFS_CFG)) begin
            cfg <= merge(cfg, w_data, w_strb, `USBIE_CFG_MASK);
        end
    end

    // usb bus reset outranks a software write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ie <= `USBIE_IE_RESET;
        end else if (ev_bus_reset) begin
            ie <= `USBIE_IE_AFTER_BRST;
        end else if (wr_go && at(aw_addr, `USBIE_OFS_IE)) begin
            ie <= merge(ie, w_data, w_strb, `USBIE_IE_MASK);
        end
    end

    assign master_irq_enable = mode[`USBIE_BIT_MASTER];
    assign control_handshake_irq_select = cfg[`USBIE_CFG_CTRL_LSB +: 2];
    assign data_in_handshake_irq_select = cfg[`USBIE_CFG_IN_LSB +: 2];
    assign data_out_handshake_irq_select = cfg[`USBIE_CFG_OUT_LSB +: 2];

    ////////////////////////////////////////////////////////////////////
    // handshake qualification

    // endpoint 0 traffic follows the control select only
    always_comb begin
        if (shake_ep == '0) begin
            shake_sel = control_handshake_irq_select;
        end else if (shake_tx) begin
            shake_sel = data_in_handshake_irq_select;
        end else begin
            shake_sel = data_out_handshake_irq_select;
        end
    end

    // select decides whether ack, nak, both or neither interrupt
    always_comb begin
        case (shake_sel)
            `USBIE_SEL_BOTH: shake_allow = 1'b1;
            `USBIE_SEL_ACK: shake_allow = !shake_nak;
            `USBIE_SEL_NAK: shake_allow = shake_nak;
            default: shake_allow = 1'b0;
        endcase
    end

    // rx bit at base + 2n, tx bit one above; setup lands on rx
    assign shake_idx = `USBIE_BIT_EP_BASE
        + {1'b0, shake_ep, shake_tx && !shake_setup};
    assign shake_vec = (shake_valid && shake_allow)
        ? (`USBIE_WORD_ONE << shake_idx) : `USBIE_WORD_ZERO;

    // bus events each own one status bit
    always_comb begin
        bus_vec = `USBIE_WORD_ZERO;
        bus_vec[`USBIE_BIT_BRST] = ev_bus_reset;
        bus_vec[`USBIE_BIT_SOF] = ev_sof;
        bus_vec[`USBIE_BIT_SUSP] = ev_suspend;
        bus_vec[`USBIE_BIT_RESUME] = ev_resume;
        bus_vec[`USBIE_BIT_HSSTAT] = ev_hs_status;
        bus_vec[`USBIE_BIT_SETUP] = ev_setup;
    end

    ////////////////////////////////////////////////////////////////////
    // status and interrupt output

    assign stat_set = shake_vec | bus_vec;
    // write-one-to-clear through the clear register
    assign stat_clr = (wr_go && at(aw_addr, `USBIE_OFS_CLR))
        ? merge(`USBIE_WORD_ZERO, w_data, w_strb, `USBIE_IE_MASK)
        : `USBIE_WORD_ZERO;

    usbie_sticky #(
        .W(32)
    ) u_status (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(stat_set),
        .clr(stat_clr),
        .flags(stat)
    );

    // registered so the pin never glitches on decode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= master_irq_enable && |(stat & ie);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    master_gate_a: assert property (
        !master_irq_enable |=> !irq
    ) else $error("irq raised with master enable off");

    irq_cause_a: assert property (
        irq |-> $past(master_irq_enable && |(stat & ie))
    ) else $error("irq without an enabled pending source");

    enabled_fire_a: assert property (
        master_irq_enable && |(stat & ie) |=> irq
    ) else $error("enabled pending source gave no irq");

    shake_latch_a: assert property (
        shake_valid && shake_allow
        |=> (stat & $past(shake_vec)) == $past(shake_vec)
            && $past(shake_vec) != `USBIE_WORD_ZERO
    ) else $error("allowed handshake not latched");

    sel_decode_a: assert property (
        shake_valid && shake_sel == `USBIE_SEL_OFF |-> shake_vec == '0
    ) else $error("handshake latched while select is off");

    in_select_a: assert property (
        shake_valid && shake_ep != '0 && shake_tx
        |-> shake_sel == data_in_handshake_irq_select
    ) else $error("data in not qualified by data-in select");

    out_select_a: assert property (
        shake_valid && shake_ep != '0 && !shake_tx
        |-> shake_sel == data_out_handshake_irq_select
    ) else $error("data out not qualified by data-out select");

    ep0_select_a: assert property (
        shake_valid && shake_ep == '0
        |-> shake_sel == control_handshake_irq_select
    ) else $error("endpoint 0 not qualified by control select");

    sof_latch_a: assert property (
        ev_sof |=> stat[`USBIE_BIT_SOF] [*2]
            or (stat[`USBIE_BIT_SOF] ##1 $past(stat_clr[`USBIE_BIT_SOF]))
    ) else $error("sof event not latched");

    bus_reset_a: assert property (
        ev_bus_reset |=> ie == `USBIE_IE_AFTER_BRST
    ) else $error("bus reset left enables other than bus reset");

    ie_write_a: assert property (
        wr_go && at(aw_addr, `USBIE_OFS_IE) && w_strb == 4'hF
            && !ev_bus_reset
        |=> ie == ($past(w_data) & `USBIE_IE_MASK) ##[0:2] bvalid
    ) else $error("enable word write not stored");

endmodule
`default_nettype wire

// ---- usbie_pkg.sv ----
// types shared by the usb interrupt enable block
package usbie_pkg;
    typedef logic [31:0] usbie_word_t;
    typedef logic [1:0] usbie_sel_t;
    typedef logic [2:0] usbie_ep_t;
    typedef logic [7:0] usbie_addr_t;
endpackage

// ---- usbie_sie_model.sv ----
// behavioural serial interface engine driving handshake and event reports
`timescale 1ns/100ps
`default_nettype none
module usbie_sie_model
    import usbie_pkg::*;
(
    input wire logic aclk,
    output logic shake_valid,
    output logic [2:0] shake_ep,
    output logic shake_tx,
    output logic shake_nak,
    output logic shake_setup,
    output logic ev_sof,
    output logic ev_suspend,
    output logic ev_resume,
    output logic ev_bus_reset,
    output logic ev_setup,
    output logic ev_hs_status
);
    logic [5:0] evs;

    // event pulses, index order matches the bench's bit table
    assign ev_bus_reset = evs[0];
    assign ev_sof = evs[1];
    assign ev_suspend = evs[2];
    assign ev_resume = evs[3];
    assign ev_hs_status = evs[4];
    assign ev_setup = evs[5];

    initial begin
        evs = 6'h00;
        shake_valid = 1'b0;
        shake_ep = 3'h0;
        shake_tx = 1'b0;
        shake_nak = 1'b0;
        shake_setup = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one ack or nak report; qualifiers scrambled once the pulse is over
    task automatic shake(input usbie_ep_t ep, input logic tx, input logic nak,
                         input logic setup);
        @(posedge aclk);
        shake_valid <= 1'b1;
        shake_ep <= ep;
        shake_tx <= tx;
        shake_nak <= nak;
        shake_setup <= setup;
        @(posedge aclk);
        shake_valid <= 1'b0;
        shake_ep <= ~ep;
        shake_tx <= ~tx;
        shake_nak <= ~nak;
        shake_setup <= ~setup;
    endtask

    // one-cycle bus event pulse
    task automatic pulse(input int b);
        @(posedge aclk);
        evs[b] <= 1'b1;
        @(posedge aclk);
        evs[b] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- usbie_sticky.sv ----
// sticky flag bank, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module usbie_sticky #(
    parameter int W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] flags
);
    // an event in the clearing cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clr) | set;
        end
    end
endmodule
`default_nettype wire
